// [sim/fpdd_host_model.sv]
// Host side model: reads the table words the way a read sequencer would.
// Assumes the words come straight from the block's registered outputs.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host decode
module fpdd_host_model (
  input  wire logic [31:0] speed_word,
  input  wire logic [31:0] desc_word,
  output logic             ds_ok,
  output logic             nd_ok,
  output logic [2:0]       drive_clks_1d
);
  // Reserved codes are never trusted as speeds; the mode counts as absent.
  assign ds_ok = speed_word[7:4] inside {[4'h1:4'h7]};
  assign nd_ok = speed_word[3:0] inside {[4'h1:4'hC]};
  // The host drives data for the mode clocks and releases it for dummies.
  assign drive_clks_1d = desc_word[7:5];
endmodule // fpdd_host_model
`default_nettype wire

// [sim/fpdd_top_chk.sv]
// Checker for the parameter table block, sees only its top ports.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Assertions
module fpdd_top_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        cfg_load,
  input wire logic [3:0]  cfg_spd_ds,
  input wire logic [3:0]  cfg_spd_nd,
  input wire logic [3:0]  cfg_support,
  input wire logic [31:0] cfg_desc,
  input wire logic [31:0] speed_word_q,
  input wire logic [31:0] support_word_q,
  input wire logic [31:0] desc_word_q,
  input wire logic        ds_valid_q,
  input wire logic        nd_valid_q,
  input wire logic        sup_4s4d4d_q,
  input wire logic        sup_1s4d4d_q,
  input wire logic        sup_1s2d2d_q,
  input wire logic        sup_1s1d1d_q,
  input wire logic [7:0]  op_2d_q,
  input wire logic [2:0]  mode_2d_q,
  input wire logic [4:0]  dummy_2d_q,
  input wire logic [7:0]  op_1d_q,
  input wire logic [2:0]  mode_1d_q,
  input wire logic [4:0]  dummy_1d_q,
  input wire logic        dummy_zero_warn_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_speed_word_ld: assert property (
    cfg_load |=> speed_word_q == {24'h00_0000, $past({cfg_spd_ds, cfg_spd_nd})})
    else $error("speed word not loaded");
  a_sup_word_ld: assert property (
    cfg_load |=> support_word_q == {28'h000_0000, $past(cfg_support)})
    else $error("support word wrong");
  a_desc_word_ld: assert property (
    cfg_load |=> desc_word_q == $past(cfg_desc)) else $error("desc word");
  a_ds_valid_dec: assert property (
    !$past(rst) |-> ds_valid_q == ($past(speed_word_q[7:4]) inside {[1:7]}))
    else $error("strobe speed validity");
  a_nd_valid_dec: assert property (
    !$past(rst) |-> nd_valid_q == ($past(speed_word_q[3:0]) inside {[1:12]}))
    else $error("plain speed validity");
  a_sup_flag_dec: assert property (
    !$past(rst) |-> {sup_4s4d4d_q, sup_1s4d4d_q, sup_1s2d2d_q, sup_1s1d1d_q}
    == $past(support_word_q[3:0])) else $error("support flags");
  a_desc_field_dec: assert property (
    !$past(rst) |-> {op_2d_q, mode_2d_q, dummy_2d_q, op_1d_q, mode_1d_q,
    dummy_1d_q} == $past(desc_word_q)) else $error("descriptor fields");
  a_dummy_zero_flag: assert property (
    !$past(rst) |-> dummy_zero_warn_q == $past(support_word_q[1] &&
    desc_word_q[20:16] == 5'h00 ||
    support_word_q[0] && desc_word_q[4:0] == 5'h00))
    else $error("zero dummy flag");
endmodule // fpdd_top_chk
`default_nettype wire

// [sim/tb_flash_param_ddr_read_decoder.sv]
// Self-checking bench: random loads against a behavioural table model.
// Assumes the design at its default parameters and a 100 ns clock.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench
module tb_flash_param_ddr_read_decoder;
  logic sys_clk = 1'b0, rst = 1'b1, cfg_load = 1'b0, chk_on = 1'b0;
  logic [3:0] cfg_spd_ds = 4'h0, cfg_spd_nd = 4'h0, cfg_support = 4'h0;
  logic [31:0] cfg_desc = 32'h0000_0000, d, ew_s, ew_u, ew_d, e_fld;
  wire [31:0] speed_word_q, support_word_q, desc_word_q;
  wire [8:0] ds_mhz_q, nd_mhz_q;
  wire ds_valid_q, nd_valid_q, dummy_zero_warn_q, h_ds, h_nd;
  wire sup_4s4d4d_q, sup_1s4d4d_q, sup_1s2d2d_q, sup_1s1d1d_q;
  wire [7:0] op_2d_q, op_1d_q;
  wire [2:0] mode_2d_q, mode_1d_q, h_dc;
  wire [4:0] dummy_2d_q, dummy_1d_q;
  logic [8:0] e_dm, e_nm;
  logic e_dv, e_nv, e_w;
  logic [3:0] e_f;
  int seed = 38072, cyc = 0, bad_count = 0, n_checks = 0, r;
  fpdd_top dut_u (.*);
  fpdd_host_model host_u (.speed_word(speed_word_q), .desc_word(desc_word_q),
    .ds_ok(h_ds), .nd_ok(h_nd), .drive_clks_1d(h_dc));
  function automatic int spd(input logic [3:0] c, input int mx);
    int t[13] = '{0, 33, 50, 66, 80, 100, 133, 166, 200, 250, 266, 333, 400};
    return (c >= 1 && c <= mx) ? t[c] : 0;
  endfunction
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: outputs differ from model", $time);
    end
  endtask
  task finish_test;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #50 sys_clk = ~sys_clk;
  // Model: words load on the edge, decoded fields follow one edge later.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test;
    end
    if (rst) begin
      {ew_u, ew_d, e_dm, e_dv, e_nm, e_nv, e_f, e_fld, e_w} <= '0;
      ew_s <= 32'h0000_00FF;
    end else begin
      e_dm <= 9'(spd(ew_s[7:4], 7));
      e_dv <= spd(ew_s[7:4], 7) != 0;
      e_nm <= 9'(spd(ew_s[3:0], 12));
      e_nv <= spd(ew_s[3:0], 12) != 0;
      e_f <= ew_u[3:0];
      e_fld <= ew_d;
      e_w <= ew_u[1] && ew_d[20:16] == 0 || ew_u[0] && ew_d[4:0] == 0;
      if (cfg_load) begin
        ew_s <= {24'h00_0000, cfg_spd_ds, cfg_spd_nd};
        ew_u <= {28'h000_0000, cfg_support};
        ew_d <= cfg_desc;
      end
    end
  end
  always @(negedge sys_clk) if (chk_on) begin
    chk({speed_word_q, ds_mhz_q, ds_valid_q, nd_mhz_q, nd_valid_q, h_ds,
         h_nd}, {ew_s, e_dm, e_dv, e_nm, e_nv, spd(ew_s[7:4], 7) != 0,
         spd(ew_s[3:0], 12) != 0});
    chk({support_word_q, sup_4s4d4d_q, sup_1s4d4d_q, sup_1s2d2d_q,
         sup_1s1d1d_q, dummy_zero_warn_q, h_dc},
        {ew_u, e_f, e_w, ew_d[7:5]});
    chk({desc_word_q, op_2d_q, mode_2d_q, dummy_2d_q, op_1d_q, mode_1d_q,
         dummy_1d_q}, {ew_d, e_fld});
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    chk_on <= 1'b1;
    // Every code in both speed fields, loaded back to back.
    for (int i = 0; i < 16; i++) begin
      cfg_load <= 1'b1;
      cfg_spd_ds <= 4'(i);
      cfg_spd_nd <= 4'(15 - i);
      @(posedge sys_clk);
    end
    // Random loads, zero dummy counts and a reset in mid-run.
    for (int k = 0; k < 400; k++) begin
      r = $random(seed);
      d = $random(seed);
      if (r[16]) d[20:16] = 5'h00;
      if (r[17]) d[4:0] = 5'h00;
      {cfg_load, cfg_spd_ds, cfg_spd_nd, cfg_support} <= 13'(r);
      cfg_desc <= d;
      rst <= (k == 200 || k == 201);
      @(posedge sys_clk);
    end
    rst <= 1'b0;
    cfg_load <= 1'b0;
    repeat (3) @(posedge sys_clk);
    finish_test;
  end
endmodule // tb_flash_param_ddr_read_decoder
bind fpdd_top fpdd_top_chk chk_u (.*);
`default_nettype wire

// [verilog/fpdd_consts.vh]
// Constants for the flash parameter read decoder: field positions, codes.
// Assumes inclusion by bare name from the design files.
`ifndef FPDD_CONSTS_VH
`define FPDD_CONSTS_VH
// ==========================================================================
// Speed word fields
`define FPDD_SPD_DS_HI      7
`define FPDD_SPD_DS_LO      4
`define FPDD_SPD_ND_HI      3
`define FPDD_SPD_ND_LO      0
`define FPDD_CODE_RSVD0     4'h0
`define FPDD_CODE_NOTCHAR   4'hE
`define FPDD_CODE_NOTSUP    4'hF
`define FPDD_DS_MAX_VALID   4'h7
`define FPDD_ND_MAX_VALID   4'hC
// ==========================================================================
// Support-flag word
`define FPDD_SUP_4S4D4D     3
`define FPDD_SUP_1S4D4D     2
`define FPDD_SUP_1S2D2D     1
`define FPDD_SUP_1S1D1D     0
`define FPDD_SUP_RSVD_W     28
// ==========================================================================
// Descriptor word fields
`define FPDD_OP_HI_HI       31
`define FPDD_OP_HI_LO       24
`define FPDD_MC_HI_HI       23
`define FPDD_MC_HI_LO       21
`define FPDD_DC_HI_HI       20
`define FPDD_DC_HI_LO       16
`define FPDD_OP_LO_HI       15
`define FPDD_OP_LO_LO       8
`define FPDD_MC_LO_HI       7
`define FPDD_MC_LO_LO       5
`define FPDD_DC_LO_HI       4
`define FPDD_DC_LO_LO       0
`define FPDD_MC_NONE        3'h0
`define FPDD_DC_NONE        5'h00
// ==========================================================================
// Speed table in MHz
`define FPDD_MHZ_W          9
`endif

// [verilog/fpdd_desc_unpack.v]
// Splits a fast read descriptor word into opcodes, mode and dummy counts.
// Assumes a same-clock caller; output is combinational.
`timescale 1ns/1ps
`default_nettype none
`include "fpdd_consts.vh"
module fpdd_desc_unpack (
  input  wire [31:0] word,
  output wire [7:0]  op_2d,
  output wire [2:0]  mode_2d,
  output wire [4:0]  dummy_2d,
  output wire [7:0]  op_1d,
  output wire [2:0]  mode_1d,
  output wire [4:0]  dummy_1d
);
  // ========================================================================
  // Fields
  assign op_2d    = word[`FPDD_OP_HI_HI:`FPDD_OP_HI_LO];
  assign mode_2d  = word[`FPDD_MC_HI_HI:`FPDD_MC_HI_LO];
  assign dummy_2d = word[`FPDD_DC_HI_HI:`FPDD_DC_HI_LO];
  assign op_1d    = word[`FPDD_OP_LO_HI:`FPDD_OP_LO_LO];
  assign mode_1d  = word[`FPDD_MC_LO_HI:`FPDD_MC_LO_LO];
  assign dummy_1d = word[`FPDD_DC_LO_HI:`FPDD_DC_LO_LO];
endmodule // fpdd_desc_unpack
`default_nettype wire

// [verilog/fpdd_speed_dec.v]
// Decodes one 4-bit maximum speed code into MHz and validity flags.
// Assumes a same-clock caller; output is combinational.
`timescale 1ns/1ps
`default_nettype none
`include "fpdd_consts.vh"
module fpdd_speed_dec #(
  parameter [3:0] MAX_VALID = `FPDD_ND_MAX_VALID
) (
  input  wire [3:0]             code,
  output reg  [`FPDD_MHZ_W-1:0] mhz,
  output reg                    valid,
  output wire                   not_sup,
  output wire                   not_char
);
  // ========================================================================
  // Decode
  assign not_sup  = (code == `FPDD_CODE_NOTSUP);
  assign not_char = (code == `FPDD_CODE_NOTCHAR);
  always @* begin
    case (code)
      4'h1:    mhz = 9'h021;
      4'h2:    mhz = 9'h032;
      4'h3:    mhz = 9'h042;
      4'h4:    mhz = 9'h050;
      4'h5:    mhz = 9'h064;
      4'h6:    mhz = 9'h085;
      4'h7:    mhz = 9'h0A6;
      4'h8:    mhz = 9'h0C8;
      4'h9:    mhz = 9'h0FA;
      4'hA:    mhz = 9'h10A;
      4'hB:    mhz = 9'h14D;
      4'hC:    mhz = 9'h190;
      default: mhz = 9'h000;
    endcase
    // Reserved codes, zero included, never count as a speed.
    valid = (code != `FPDD_CODE_RSVD0) && (code <= MAX_VALID);
    if (!valid) begin
      mhz = 9'h000;
    end
  end
endmodule // fpdd_speed_dec
`default_nettype wire

// [verilog/fpdd_top.v]
// Parameter table words for quad speed, double-rate support, descriptors.
// Builds the three table words from configuration ports and decodes them
// back into registered fields for a read sequencer on the same clock.
//
// Notes on behaviour
// - Quad speed with strobe: F unsupported, E uncharacterized, 1..7 speeds.
// - Codes 8 to D of the strobe speed field are reserved, never valid.
// - Quad speed without strobe: F, E special; 1..C map to speeds; 0 reserved.
// - Support word bits 31 to 4 always read as zero.
// - Support bit 3 flags quad-opcode quad double-rate fast read.
// - Support bit 2 flags single-opcode quad double-rate fast read.
// - Support bit 1 flags single-opcode dual double-rate fast read.
// - Support bit 0 flags single-line double-rate fast read.
// - Descriptor top byte holds the 1S-2D-2D opcode.
// - Bits 23 to 21 give 1S-2D-2D mode clocks; zero means none.
// - Mode counts are clock cycles, not bits transferred.
// - Bits 20 to 16 give 1S-2D-2D dummy clocks; zero means none.
// - Dummy counts should be nonzero to avoid bus contention; zero is stored as given and only raises dummy_zero_warn_q for a supported mode.
// - Descriptor second byte holds the 1S-1D-1D opcode.
// - Bits 7 to 5 give 1S-1D-1D mode clocks; eight bits encode as four.
// - Low five bits give 1S-1D-1D dummy clocks; zero means none.
`timescale 1ns/1ps
`default_nettype none
`include "fpdd_consts.vh"
module fpdd_top #(
  parameter [3:0] SPD_DS_CODE  = `FPDD_CODE_NOTSUP,
  parameter [3:0] SPD_ND_CODE  = `FPDD_CODE_NOTSUP,
  parameter [7:0] OP_2D        = 8'h00,
  parameter [2:0] MODE_2D      = `FPDD_MC_NONE,
  parameter [4:0] DUMMY_2D     = `FPDD_DC_NONE,
  parameter [7:0] OP_1D        = 8'h00,
  parameter [2:0] MODE_1D      = `FPDD_MC_NONE,
  parameter [4:0] DUMMY_1D     = `FPDD_DC_NONE
) (
  input  wire                   sys_clk,
  input  wire                   rst,
  input  wire                   cfg_load,
  input  wire [3:0]             cfg_spd_ds,
  input  wire [3:0]             cfg_spd_nd,
  input  wire [3:0]             cfg_support,
  input  wire [31:0]            cfg_desc,
  output reg  [31:0]            speed_word_q,
  output reg  [31:0]            support_word_q,
  output reg  [31:0]            desc_word_q,
  output reg  [`FPDD_MHZ_W-1:0] ds_mhz_q,
  output reg                    ds_valid_q,
  output reg  [`FPDD_MHZ_W-1:0] nd_mhz_q,
  output reg                    nd_valid_q,
  output reg                    sup_4s4d4d_q,
  output reg                    sup_1s4d4d_q,
  output reg                    sup_1s2d2d_q,
  output reg                    sup_1s1d1d_q,
  output reg  [7:0]             op_2d_q,
  output reg  [2:0]             mode_2d_q,
  output reg  [4:0]             dummy_2d_q,
  output reg  [7:0]             op_1d_q,
  output reg  [2:0]             mode_1d_q,
  output reg  [4:0]             dummy_1d_q,
  output reg                    dummy_zero_warn_q
);
  // ========================================================================
  // Table word build
  reg  [3:0]             spd_ds_d;
  reg  [3:0]             spd_nd_d;
  wire [`FPDD_MHZ_W-1:0] ds_mhz;
  wire [`FPDD_MHZ_W-1:0] nd_mhz;
  wire                   ds_valid;
  wire                   nd_valid;
  wire [7:0]             op_2d;
  wire [2:0]             mode_2d;
  wire [4:0]             dummy_2d;
  wire [7:0]             op_1d;
  wire [2:0]             mode_1d;
  wire [4:0]             dummy_1d;

  always @(posedge sys_clk) begin
    if (rst) begin
      speed_word_q   <= {24'h00_0000, SPD_DS_CODE, SPD_ND_CODE};
      support_word_q <= 32'h0000_0000;
      desc_word_q    <= {OP_2D, MODE_2D, DUMMY_2D, OP_1D, MODE_1D, DUMMY_1D};
    end else if (cfg_load) begin
      // Only the low byte of the speed word belongs to this block.
      speed_word_q   <= {24'h00_0000, cfg_spd_ds, cfg_spd_nd};
      // Reserved flag bits are forced low, whatever the source offers.
      support_word_q <= {{`FPDD_SUP_RSVD_W{1'b0}}, cfg_support};
      // Mode counts are stored as clocks exactly as given.
      desc_word_q    <= cfg_desc;
    end
  end

  // ========================================================================
  // Decode
  always @* begin
    spd_ds_d = speed_word_q[`FPDD_SPD_DS_HI:`FPDD_SPD_DS_LO];
    spd_nd_d = speed_word_q[`FPDD_SPD_ND_HI:`FPDD_SPD_ND_LO];
  end

  fpdd_speed_dec #(
    .MAX_VALID (`FPDD_DS_MAX_VALID)
  ) u_ds (
    .code     (spd_ds_d),
    .mhz      (ds_mhz),
    .valid    (ds_valid),
    .not_sup  (),
    .not_char ()
  );

  fpdd_speed_dec #(
    .MAX_VALID (`FPDD_ND_MAX_VALID)
  ) u_nd (
    .code     (spd_nd_d),
    .mhz      (nd_mhz),
    .valid    (nd_valid),
    .not_sup  (),
    .not_char ()
  );

  fpdd_desc_unpack u_desc (
    .word     (desc_word_q),
    .op_2d    (op_2d),
    .mode_2d  (mode_2d),
    .dummy_2d (dummy_2d),
    .op_1d    (op_1d),
    .mode_1d  (mode_1d),
    .dummy_1d (dummy_1d)
  );

  // ========================================================================
  // Registered decoded fields, one cycle behind the table words
  always @(posedge sys_clk) begin
    if (rst) begin
      ds_mhz_q          <= {`FPDD_MHZ_W{1'b0}};
      ds_valid_q        <= 1'b0;
      nd_mhz_q          <= {`FPDD_MHZ_W{1'b0}};
      nd_valid_q        <= 1'b0;
      sup_4s4d4d_q      <= 1'b0;
      sup_1s4d4d_q      <= 1'b0;
      sup_1s2d2d_q      <= 1'b0;
      sup_1s1d1d_q      <= 1'b0;
      op_2d_q           <= 8'h00;
      mode_2d_q         <= 3'h0;
      dummy_2d_q        <= 5'h00;
      op_1d_q           <= 8'h00;
      mode_1d_q         <= 3'h0;
      dummy_1d_q        <= 5'h00;
      dummy_zero_warn_q <= 1'b0;
    end else begin
      // Reserved codes come out as invalid with zero speed.
      ds_mhz_q     <= ds_mhz;
      ds_valid_q   <= ds_valid;
      nd_mhz_q     <= nd_mhz;
      nd_valid_q   <= nd_valid;
      sup_4s4d4d_q <= support_word_q[`FPDD_SUP_4S4D4D];
      sup_1s4d4d_q <= support_word_q[`FPDD_SUP_1S4D4D];
      sup_1s2d2d_q <= support_word_q[`FPDD_SUP_1S2D2D];
      sup_1s1d1d_q <= support_word_q[`FPDD_SUP_1S1D1D];
      op_2d_q      <= op_2d;
      mode_2d_q    <= mode_2d;
      dummy_2d_q   <= dummy_2d;
      op_1d_q      <= op_1d;
      mode_1d_q    <= mode_1d;
      dummy_1d_q   <= dummy_1d;
      // A supported mode with zero dummy clocks risks a turnaround clash
      // between host and flash, so it is flagged rather than refused.
      dummy_zero_warn_q <=
        (support_word_q[`FPDD_SUP_1S2D2D] && dummy_2d == `FPDD_DC_NONE) ||
        (support_word_q[`FPDD_SUP_1S1D1D] && dummy_1d == `FPDD_DC_NONE);
    end
  end
endmodule // fpdd_top
`default_nettype wire
